// *** olf_cfg.svh ***
// register offsets, field positions and reset values of the list and frame registers
// assumes byte addresses on a 12-bit register port, one 32-bit word per register
`ifndef OLF_CFG_SVH
`define OLF_CFG_SVH
`define OLF_ADDR_W         12
`define OLF_OFS_IRQ_DIS    12'h414
`define OLF_OFS_COMM       12'h418
`define OLF_OFS_PCUR       12'h41c
`define OLF_OFS_CTL_HEAD   12'h420
`define OLF_OFS_CTL_CUR    12'h424
`define OLF_OFS_BLK_HEAD   12'h428
`define OLF_OFS_BLK_CUR    12'h42c
`define OLF_OFS_DONE       12'h430
`define OLF_OFS_PERIOD     12'h434
`define OLF_OFS_COUNTDOWN  12'h438
`define OLF_OFS_FRAME_CNT  12'h43c
`define OLF_OFS_THRESH     12'h440
`define OLF_COMM_LSB       8
`define OLF_PTR_LSB        4
`define OLF_TOGGLE_BIT     31
`define OLF_MAXPKT_MSB     30
`define OLF_MAXPKT_LSB     16
`define OLF_PERIOD_MSB     13
`define OLF_DIS_DONE_BIT   1
`define OLF_DIS_OVR_BIT    0
`define OLF_PERIOD_RST     14'h2edf
`define OLF_THRESH_RST     14'h0000
`endif

// *** olf_pkg.sv ***
// types shared by the list and frame register block and its frame timer
// assumes the field positions in olf_cfg.svh; the widths here are written out to match them
package olf_pkg;
	typedef logic [31:0] olf_word_t;
	typedef logic [27:0] olf_ptr_t;
	typedef logic [13:0] olf_bits_t;
	typedef logic [14:0] olf_pkt_t;
	typedef logic [15:0] olf_fnum_t;
	typedef enum logic [2:0] {
		OLF_IDLE    = 3'b000,
		OLF_FN_WR   = 3'b001,
		OLF_SOF_SET = 3'b010,
		OLF_DQ_WR   = 3'b011,
		OLF_DQ_SET  = 3'b100
	} olf_seq_e;
endpackage

// *** olf_timer_if.sv ***
// signals between the register block and the frame timer
// assumes both ends run on the same controller clock
interface olf_timer_if;
	import olf_pkg::*;
	olf_bits_t period;
	logic      period_toggle;
	olf_pkt_t  max_packet_bits;
	logic      enter_op;
	logic      soft_reset;
	logic      bit_tick;
	logic      xfer_busy;
	olf_bits_t countdown;
	logic      countdown_toggle;
	olf_fnum_t frame_count;
	logic      frame_boundary;
	olf_pkt_t  max_count;
	modport regs (
		output period, period_toggle, max_packet_bits, enter_op, soft_reset,
		output bit_tick, xfer_busy,
		input  countdown, countdown_toggle, frame_count, frame_boundary, max_count
	);
	modport timer (
		input  period, period_toggle, max_packet_bits, enter_op, soft_reset,
		input  bit_tick, xfer_busy,
		output countdown, countdown_toggle, frame_count, frame_boundary, max_count
	);
endinterface

// *** olf_frame_timer.sv ***
// frame countdown, frame number and largest packet counter
// assumes bit_tick is a one-cycle pulse per bit time
module olf_frame_timer (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// register side
	olf_timer_if.timer tif
);
	import olf_pkg::*;
	logic rst;
	logic running;
	logic reload;
	assign rst = i_sys_rst | tif.soft_reset;
	assign reload = tif.enter_op | (running & tif.bit_tick & (tif.countdown == 14'h0000));
	// ****************************************
	// countdown and frame number
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			running               <= 1'b0;
			tif.countdown         <= 14'h0000;
			tif.countdown_toggle  <= 1'b0;
			tif.frame_count       <= 16'h0000;
			tif.frame_boundary    <= 1'b0;
		end else begin
			running            <= running | tif.enter_op;
			tif.frame_boundary <= reload;
			if (reload) begin
				tif.countdown        <= tif.period;
				tif.countdown_toggle <= tif.period_toggle;
				tif.frame_count      <= tif.frame_count + 16'h0001;
			end else if (running & tif.bit_tick) begin
				tif.countdown <= tif.countdown - 14'h0001;
			end
		end
	end
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			tif.max_count <= 15'h0000;
		end else if (reload) begin
			tif.max_count <= tif.max_packet_bits;
		end else if (tif.bit_tick & tif.xfer_busy & (tif.max_count != 15'h0000)) begin
			tif.max_count <= tif.max_count - 15'h0001;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	property p_count_down;
		@(posedge i_mclk) disable iff (rst)
		running & tif.bit_tick & !tif.enter_op & (tif.countdown != 14'h0000)
			|=> tif.countdown == $past(tif.countdown) - 14'h0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("countdown missed a bit time");
	property p_toggle_copy;
		@(posedge i_mclk) disable iff (rst)
		reload |=> tif.frame_boundary && tif.countdown_toggle == $past(tif.period_toggle);
	endproperty
	a_toggle_copy: assert property (p_toggle_copy) else $error("toggle not copied");
	property p_frame_inc;
		@(posedge i_mclk) disable iff (rst)
		reload |=> tif.frame_count == $past(tif.frame_count) + 16'h0001;
	endproperty
	a_frame_inc: assert property (p_frame_inc) else $error("frame number not advanced");
	property p_pkt_load;
		@(posedge i_mclk) disable iff (rst)
		reload |=> tif.max_count == $past(tif.max_packet_bits);
	endproperty
	a_pkt_load: assert property (p_pkt_load) else $error("packet counter not loaded");
endmodule

// *** olf_list_frame_regs.sv ***
// list pointer and frame timing registers of a usb host controller
// assumes a single clock, a plain register port and a scheduler driving the list events
`include "olf_cfg.svh"
module olf_list_frame_regs (
	// clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	// register port
	input  wire logic [11:0]           i_addr,
	input  wire olf_pkg::olf_word_t    i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output olf_pkg::olf_word_t         o_rdata,
	// controller state
	input  wire logic                  i_soft_reset_request,
	input  wire logic                  i_enter_operational,
	input  wire logic                  i_control_list_on,
	input  wire logic                  i_bulk_list_on,
	input  wire logic                  i_control_list_pending,
	input  wire logic                  i_bulk_list_pending,
	input  wire logic                  i_bit_tick,
	input  wire logic                  i_xfer_busy,
	// scheduler events
	input  wire logic                  i_periodic_served,
	input  wire olf_pkg::olf_word_t    i_periodic_next,
	input  wire logic                  i_control_served,
	input  wire olf_pkg::olf_word_t    i_control_next,
	input  wire logic                  i_control_end,
	input  wire logic                  i_bulk_served,
	input  wire olf_pkg::olf_word_t    i_bulk_next,
	input  wire logic                  i_bulk_end,
	input  wire logic                  i_td_done,
	input  wire olf_pkg::olf_word_t    i_td_addr,
	input  wire logic                  i_done_writeback,
	// list flag clears
	output logic                       o_control_pending_clr,
	output logic                       o_bulk_pending_clr,
	// next link write into a finished descriptor
	output logic                       o_next_link_wr,
	output olf_pkg::olf_word_t         o_next_link_addr,
	output olf_pkg::olf_word_t         o_next_link_field,
	// communication area write
	output logic                       o_comm_wr,
	output logic                       o_comm_sel_done,
	output olf_pkg::olf_word_t         o_comm_area,
	output olf_pkg::olf_word_t         o_comm_data,
	// status flag sets and interrupt disables
	output logic                       o_done_queue_written_flag,
	output logic                       o_frame_start_flag,
	output logic                       o_done_irq_disable,
	output logic                       o_overrun_irq_disable,
	// frame timing
	output logic                       o_frame_start,
	output olf_pkg::olf_pkt_t          o_max_packet_bits,
	output logic                       o_periodic_priority,
	output logic                       o_periodic_go
);
	import olf_pkg::*;
	// ****************************************
	// declarations
	// ****************************************
	localparam logic [11:0] HEAD_OFS [2] = '{`OLF_OFS_CTL_HEAD, `OLF_OFS_BLK_HEAD};
	localparam logic [11:0] CUR_OFS  [2] = '{`OLF_OFS_CTL_CUR, `OLF_OFS_BLK_CUR};
	olf_timer_if tif ();
	logic                               rst;
	logic [31:`OLF_COMM_LSB]            comm_base;
	olf_ptr_t                           pcur;
	olf_ptr_t                           done_head;
	olf_bits_t                          period;
	logic                               period_toggle;
	olf_pkt_t                           max_packet_bits;
	olf_bits_t                          thresh;
	olf_ptr_t                           list_head   [2];
	olf_ptr_t                           list_cur    [2];
	logic                               pend_clr    [2];
	logic                               list_on     [2];
	logic                               list_served [2];
	logic                               list_end    [2];
	logic                               list_pend   [2];
	olf_word_t                          list_next   [2];
	logic                               head_wr     [2];
	logic                               cur_sw_wr   [2];
	logic                               list_reload [2];
	olf_seq_e                           state;
	olf_seq_e                           next_state;
	logic                               fn_req;
	logic                               dq_req;
	logic                               prio_pend;
	logic                               prio_hit;
	logic                               wr_comm;
	logic                               wr_period;
	logic                               wr_thresh;
	logic                               wr_dis;
	olf_word_t                          rd_mux;
	// ****************************************
	// timer hookup
	// ****************************************
	assign rst                 = i_sys_rst | i_soft_reset_request;
	assign tif.period          = period;
	assign tif.period_toggle   = period_toggle;
	assign tif.max_packet_bits = max_packet_bits;
	assign tif.enter_op        = i_enter_operational;
	assign tif.soft_reset      = i_soft_reset_request;
	assign tif.bit_tick        = i_bit_tick;
	assign tif.xfer_busy       = i_xfer_busy;
	assign o_frame_start       = tif.frame_boundary;
	assign o_max_packet_bits   = tif.max_count;
	olf_frame_timer u_timer (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.tif       (tif)
	);
	// ****************************************
	// address decode
	// ****************************************
	assign wr_comm   = i_wr && (i_addr == `OLF_OFS_COMM);
	assign wr_period = i_wr && (i_addr == `OLF_OFS_PERIOD);
	assign wr_thresh = i_wr && (i_addr == `OLF_OFS_THRESH);
	assign wr_dis    = i_wr && (i_addr == `OLF_OFS_IRQ_DIS);
	assign rd_mux =
		(i_addr == `OLF_OFS_COMM)      ? {comm_base, 8'h00} :
		(i_addr == `OLF_OFS_PCUR)      ? {pcur, 4'h0} :
		(i_addr == `OLF_OFS_CTL_HEAD)  ? {list_head[0], 4'h0} :
		(i_addr == `OLF_OFS_CTL_CUR)   ? {list_cur[0], 4'h0} :
		(i_addr == `OLF_OFS_BLK_HEAD)  ? {list_head[1], 4'h0} :
		(i_addr == `OLF_OFS_BLK_CUR)   ? {list_cur[1], 4'h0} :
		(i_addr == `OLF_OFS_DONE)      ? {done_head, 4'h0} :
		(i_addr == `OLF_OFS_PERIOD)    ? {period_toggle, max_packet_bits, 2'b00, period} :
		(i_addr == `OLF_OFS_COUNTDOWN) ? {tif.countdown_toggle, 17'h00000, tif.countdown} :
		(i_addr == `OLF_OFS_FRAME_CNT) ? {16'h0000, tif.frame_count} :
		(i_addr == `OLF_OFS_THRESH)    ? {18'h00000, thresh} :
		32'h00000000;
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_rdata <= 32'h00000000;
		end else begin
			o_rdata <= i_rd ? rd_mux : 32'h00000000;
		end
	end
	// ****************************************
	// communication area base and interrupt disables
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			comm_base <= 24'h000000;
		end else if (wr_comm) begin
			comm_base <= i_wdata[31:`OLF_COMM_LSB];
		end
	end
	assign o_comm_area = {comm_base, 8'h00};
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			o_done_irq_disable    <= 1'b0;
			o_overrun_irq_disable <= 1'b0;
		end else begin
			o_done_irq_disable    <= wr_dis & i_wdata[`OLF_DIS_DONE_BIT];
			o_overrun_irq_disable <= wr_dis & i_wdata[`OLF_DIS_OVR_BIT];
		end
	end
	// ****************************************
	// frame period and priority threshold
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			period          <= `OLF_PERIOD_RST;
			period_toggle   <= 1'b0;
			max_packet_bits <= 15'h0000;
		end else if (wr_period) begin
			period          <= i_wdata[`OLF_PERIOD_MSB:0];
			period_toggle   <= i_wdata[`OLF_TOGGLE_BIT];
			max_packet_bits <= i_wdata[`OLF_MAXPKT_MSB:`OLF_MAXPKT_LSB];
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			thresh <= `OLF_THRESH_RST;
		end else if (wr_thresh) begin
			thresh <= i_wdata[`OLF_PERIOD_MSB:0];
		end
	end
	// ****************************************
	// periodic priority
	// ****************************************
	assign prio_hit = i_bit_tick && (tif.countdown == thresh);
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			prio_pend           <= 1'b0;
			o_periodic_priority <= 1'b0;
			o_periodic_go       <= 1'b0;
		end else begin
			prio_pend           <= prio_hit | (prio_pend & ~tif.frame_boundary);
			o_periodic_priority <= prio_pend;
			o_periodic_go       <= prio_pend & ~i_xfer_busy;
		end
	end
	// ****************************************
	// periodic current pointer
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			pcur <= 28'h0000000;
		end else if (i_periodic_served) begin
			pcur <= i_periodic_next[31:`OLF_PTR_LSB];
		end
	end
	// ****************************************
	// control and bulk lists
	// ****************************************
	assign list_on[0]     = i_control_list_on;
	assign list_on[1]     = i_bulk_list_on;
	assign list_served[0] = i_control_served;
	assign list_served[1] = i_bulk_served;
	assign list_end[0]    = i_control_end;
	assign list_end[1]    = i_bulk_end;
	assign list_pend[0]   = i_control_list_pending;
	assign list_pend[1]   = i_bulk_list_pending;
	assign list_next[0]   = i_control_next;
	assign list_next[1]   = i_bulk_next;
	assign o_control_pending_clr = pend_clr[0];
	assign o_bulk_pending_clr    = pend_clr[1];
	for (genvar l = 0; l < 2; l++) begin : gen_list
		assign head_wr[l]     = i_wr && (i_addr == HEAD_OFS[l]);
		assign cur_sw_wr[l]   = i_wr && (i_addr == CUR_OFS[l]) && !list_on[l];
		assign list_reload[l] = list_end[l] && list_pend[l];
		always_ff @(posedge i_mclk) begin
			if (rst) begin
				list_head[l] <= 28'h0000000;
				list_cur[l]  <= 28'h0000000;
				pend_clr[l]  <= 1'b0;
			end else begin
				pend_clr[l] <= list_reload[l];
				if (head_wr[l]) begin
					list_head[l] <= i_wdata[31:`OLF_PTR_LSB];
				end
				if (list_reload[l]) begin
					list_cur[l] <= list_head[l];
				end else if (list_served[l]) begin
					list_cur[l] <= list_next[l][31:`OLF_PTR_LSB];
				end else if (cur_sw_wr[l]) begin
					list_cur[l] <= i_wdata[31:`OLF_PTR_LSB];
				end
			end
		end
	end
	// ****************************************
	// done queue
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			done_head         <= 28'h0000000;
			o_next_link_wr    <= 1'b0;
			o_next_link_addr  <= 32'h00000000;
			o_next_link_field <= 32'h00000000;
		end else begin
			o_next_link_wr <= i_td_done;
			if (i_td_done) begin
				o_next_link_addr  <= {i_td_addr[31:`OLF_PTR_LSB], 4'h0};
				o_next_link_field <= {done_head, 4'h0};
				done_head         <= i_td_addr[31:`OLF_PTR_LSB];
			end else if (next_state == OLF_DQ_WR) begin
				done_head <= 28'h0000000;
			end
		end
	end
	// ****************************************
	// communication area write sequencer
	// ****************************************
	always_comb begin
		next_state = OLF_IDLE;
		case (state)
			OLF_IDLE: begin
				if (fn_req) begin
					next_state = OLF_FN_WR;
				end else if (dq_req && !i_td_done) begin
					next_state = OLF_DQ_WR;
				end
			end
			OLF_FN_WR: begin
				next_state = OLF_SOF_SET;
			end
			OLF_DQ_WR: begin
				next_state = OLF_DQ_SET;
			end
			OLF_SOF_SET: begin
				next_state = OLF_IDLE;
			end
			OLF_DQ_SET: begin
				next_state = OLF_IDLE;
			end
			default: begin
				next_state = OLF_IDLE;
			end
		endcase
	end
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			state  <= OLF_IDLE;
			fn_req <= 1'b0;
			dq_req <= 1'b0;
		end else begin
			state  <= next_state;
			fn_req <= tif.frame_boundary | (fn_req & (next_state != OLF_FN_WR));
			dq_req <= i_done_writeback | (dq_req & (next_state != OLF_DQ_WR));
		end
	end
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			o_comm_wr                 <= 1'b0;
			o_comm_sel_done           <= 1'b0;
			o_comm_data               <= 32'h00000000;
			o_frame_start_flag        <= 1'b0;
			o_done_queue_written_flag <= 1'b0;
		end else begin
			o_comm_wr                 <= (next_state == OLF_FN_WR) || (next_state == OLF_DQ_WR);
			o_comm_sel_done           <= next_state == OLF_DQ_WR;
			o_comm_data               <= (next_state == OLF_DQ_WR) ? {done_head, 4'h0}
				: {16'h0000, tif.frame_count};
			o_frame_start_flag        <= next_state == OLF_SOF_SET;
			o_done_queue_written_flag <= next_state == OLF_DQ_SET;
		end
	end
	// ****************************************
	// checks
	// ****************************************
	property p_comm_low;
		@(posedge i_mclk) disable iff (rst)
		i_rd && (i_addr == `OLF_OFS_COMM) |=> o_rdata[7:0] == 8'h00;
	endproperty
	a_comm_low: assert property (p_comm_low) else $error("base pointer low byte set");
	property p_ptr_low;
		@(posedge i_mclk) disable iff (rst)
		i_rd && (i_addr >= `OLF_OFS_PCUR) && (i_addr <= `OLF_OFS_DONE) |=> o_rdata[3:0] == 4'h0;
	endproperty
	a_ptr_low: assert property (p_ptr_low) else $error("pointer low nibble set");
	property p_ctl_reload;
		@(posedge i_mclk) disable iff (rst)
		i_control_end && i_control_list_pending
			|=> o_control_pending_clr && list_cur[0] == $past(list_head[0]);
	endproperty
	a_ctl_reload: assert property (p_ctl_reload) else $error("control list not reloaded");
	property p_ctl_locked;
		@(posedge i_mclk) disable iff (rst)
		i_control_list_on && !i_control_served && !i_control_end |=> $stable(list_cur[0]);
	endproperty
	a_ctl_locked: assert property (p_ctl_locked) else $error("control pointer changed while on");
	property p_done_link;
		@(posedge i_mclk) disable iff (rst)
		i_td_done |=> o_next_link_wr && o_next_link_field == {$past(done_head), 4'h0}
			&& done_head == $past(i_td_addr[31:4]);
	endproperty
	a_done_link: assert property (p_done_link) else $error("done queue link wrong");
	property p_done_wb;
		@(posedge i_mclk) disable iff (rst)
		$rose(o_comm_sel_done) |-> ##1 o_done_queue_written_flag;
	endproperty
	a_done_wb: assert property (p_done_wb) else $error("done write flag missing");
	property p_sof_seq;
		@(posedge i_mclk) disable iff (rst)
		tif.frame_boundary && state == OLF_IDLE && !dq_req
			|-> ##2 o_comm_wr && !o_comm_sel_done ##1 o_frame_start_flag;
	endproperty
	a_sof_seq: assert property (p_sof_seq) else $error("frame number write order broken");
	property p_dis_done;
		@(posedge i_mclk) disable iff (rst)
		wr_dis |=> o_done_irq_disable == $past(i_wdata[1]) && o_overrun_irq_disable == $past(i_wdata[0]);
	endproperty
	a_dis_done: assert property (p_dis_done) else $error("interrupt disable mismatch");
	property p_period_rst;
		@(posedge i_mclk)
		i_soft_reset_request |=> period == 14'h2edf;
	endproperty
	a_period_rst: assert property (p_period_rst) else $error("frame period not reset");
endmodule

// *** olf_sw_model.sv ***
// software side model: keeps the bulk list pending flag
// assumes one clock and a one-cycle add pulse
// *****
// pending flag
// *****
module olf_sw_model (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	// list work
	input  wire logic i_add_bulk,
	input  wire logic i_clr,
	output logic      o_bulk_pending
);
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_bulk_pending <= 1'b0;
		end else if (i_add_bulk) begin
			o_bulk_pending <= 1'b1;
		end else if (i_clr) begin
			o_bulk_pending <= 1'b0;
		end
	end
endmodule

// *** test_olf_list_frame_regs.sv ***
// bench of the list and frame register block
// assumes olf_cfg.svh offsets and the software model
`include "olf_cfg.svh"
module test_olf_list_frame_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import olf_pkg::*;
	logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, add = 0, tick_en = 0;
	logic i_soft_reset_request = 0, i_enter_operational = 0, i_bit_tick = 0, i_xfer_busy = 0;
	logic i_control_list_on = 0, i_bulk_list_on = 0, i_control_list_pending = 0;
	logic i_periodic_served = 0, i_control_served = 0, i_control_end = 0, i_bulk_served = 0;
	logic i_bulk_end = 0, i_td_done = 0, i_done_writeback = 0, i_bulk_list_pending;
	logic [11:0] i_addr = 0;
	olf_word_t i_wdata = 0, i_periodic_next = 0, i_control_next = 0, i_bulk_next = 0;
	olf_word_t i_td_addr = 0, rv, o_rdata, o_next_link_addr, o_next_link_field;
	olf_word_t o_comm_area, o_comm_data;
	logic o_control_pending_clr, o_bulk_pending_clr, o_next_link_wr, o_comm_wr, o_comm_sel_done;
	logic o_done_queue_written_flag, o_frame_start_flag, o_done_irq_disable;
	logic o_overrun_irq_disable, o_frame_start, o_periodic_priority, o_periodic_go;
	olf_pkt_t o_max_packet_bits;
	int miscompares = 0, check_count = 0, cyc = 0;
	olf_list_frame_regs dut_u (.*);
	olf_sw_model sw_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_add_bulk(add),
		.i_clr(o_bulk_pending_clr), .o_bulk_pending(i_bulk_list_pending));
	// *****
	// clock, ticks and tasks
	// *****
	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) i_bit_tick <= tick_en & ~i_bit_tick;
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input olf_word_t s, input olf_word_t e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic ev;
		@(posedge i_mclk);
		{i_wr, i_rd, add, i_enter_operational, i_control_end, i_bulk_end} <= '0;
		{i_periodic_served, i_control_served, i_td_done, i_done_writeback} <= '0;
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input olf_word_t d);
		@(posedge i_mclk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		ev;
	endtask
	task automatic rd(input logic [11:0] a, input olf_word_t e, input olf_word_t m = '1);
		@(posedge i_mclk);
		{i_rd, i_addr} <= {1'b1, a};
		ev;
		#1 rv = o_rdata & m;
		chk(rv, e);
	endtask
	// *****
	// scenarios
	// *****
	task automatic t_regs;
		rd(12'h434, 32'h2edf);
		rd(12'h440, 32'h0);
		rd(12'h400, 32'h0);
		wr(12'h418, 32'hffffffff);
		rd(12'h418, 32'hffffff00);
		chk(o_comm_area, 32'hffffff00);
		wr(12'h41c, 32'hffffffff);
		rd(12'h41c, 32'h0);
		for (int i = 1; i < 3; i++) begin
			wr(12'h414, i);
			#1 chk({o_done_irq_disable, o_overrun_irq_disable}, i);
		end
	endtask
	task automatic t_lists;
		wr(12'h424, 32'h50);
		rd(12'h424, 32'h50);
		wr(12'h42c, 32'h3000);
		rd(12'h42c, 32'h3000);
		wr(12'h420, 32'hffffffff);
		{i_control_list_pending, i_control_end} <= 2'b11;
		ev;
		#1 chk(o_control_pending_clr, 1);
		i_control_list_pending <= 0;
		i_control_list_on <= 1;
		wr(12'h424, 32'h100);
		rd(12'h424, 32'hfffffff0);
		{i_control_served, i_control_next} <= {1'b1, 32'h0};
		ev;
		rd(12'h424, 32'h0);
		wr(12'h428, 32'h2000);
		add <= 1;
		ev;
		i_bulk_end <= 1;
		ev;
		rd(12'h42c, 32'h2000);
		chk(i_bulk_list_pending, 0);
		{i_periodic_served, i_periodic_next} <= {1'b1, 32'h1238};
		ev;
		rd(12'h41c, 32'h1230);
	endtask
	task automatic t_done;
		for (int i = 1; i < 3; i++) begin
			{i_td_done, i_td_addr} <= {1'b1, 32'h1230 * i};
			ev;
			#1 chk(o_next_link_wr, 1);
			chk(o_next_link_field, 32'h1230 * (i - 1));
			chk(o_next_link_addr, 32'h1230 * i);
		end
		rd(12'h430, 32'h2460);
		i_done_writeback <= 1;
		ev;
		@(posedge i_mclk);
		#1 chk(o_comm_wr, 1);
		chk(o_comm_sel_done, 1);
		chk(o_comm_data, 32'h2460);
		@(posedge i_mclk);
		#1 chk(o_done_queue_written_flag, 1);
		rd(12'h430, 32'h0);
	endtask
	task automatic t_frame;
		wr(12'h440, 32'h2);
		wr(12'h434, 32'h80050004);
		tick_en <= 1;
		i_enter_operational <= 1;
		ev;
		chk(o_frame_start, 1);
		chk(o_max_packet_bits, 15'h0005);
		rd(12'h43c, 32'h1);
		chk(o_comm_wr, 1);
		chk(o_comm_data, 32'h1);
		@(posedge i_mclk);
		#1 chk(o_frame_start_flag, 1);
		chk(o_periodic_priority, 0);
		repeat (3) @(posedge i_mclk);
		#1 chk(o_periodic_go, 1);
		i_xfer_busy <= 1;
		@(posedge i_mclk);
		#1 chk(o_periodic_go, 0);
		chk(o_periodic_priority, 1);
		chk(o_max_packet_bits, 15'h0004);
		i_xfer_busy <= 0;
		repeat (2) @(posedge i_mclk);
		#1 chk(o_frame_start, 1);
		chk(o_max_packet_bits, 15'h0005);
		rd(12'h43c, 32'h2);
		chk(o_periodic_priority, 0);
		rd(12'h438, 32'h80000003);
	endtask
	task automatic t_soft;
		i_soft_reset_request <= 1;
		ev;
		i_soft_reset_request <= 0;
		rd(12'h434, 32'h2edf);
		rd(12'h440, 32'h2);
		rd(12'h43c, 32'h0);
		rd(12'h424, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 0;
		t_regs;
		t_lists;
		t_done;
		t_frame;
		t_soft;
		stop_test;
	end
endmodule
